// file: verilog/qdc_cfg.svh
// constants of the quad converter command register block
`ifndef QDC_CFG_SVH
`define QDC_CFG_SVH

// ****************************************************************
// serial frame layout
// ****************************************************************
`define QDC_FRAME_BITS     5'h18
`define QDC_FRAME_RW_BIT   23
`define QDC_FRAME_ZERO_HI  22
`define QDC_FRAME_ZERO_LO  20
`define QDC_FRAME_ADDR_HI  19
`define QDC_FRAME_ADDR_LO  16
`define QDC_FRAME_RESET    24'h00_0000

// ****************************************************************
// register addresses
// ****************************************************************
`define QDC_ADDR_CMD       4'h0
`define QDC_ADDR_DAC_BASE  2'h1

// ****************************************************************
// command register fields and reset values
// ****************************************************************
`define QDC_CMD_AB         15
`define QDC_CMD_SYNC_LOAD  14
`define QDC_CMD_RST        13
`define QDC_CMD_PD_LOW     12
`define QDC_CMD_PD_HIGH    11
`define QDC_CMD_RSVD       10
`define QDC_CMD_GPIO1      9
`define QDC_CMD_GPIO0      8
`define QDC_CMD_RESET      16'h033c
`define QDC_CMD_LOW_FIXED  8'h3c
`define QDC_GPIO_RESET     2'h3
`define QDC_DATA_RESET     16'h0000

// ****************************************************************
// timing
// ****************************************************************
`define QDC_SRST_CYCLES    3'h4

`endif

// file: verilog/qdc_pkg.sv
// types shared by the quad converter command register block
package qdc_pkg;

  // soft reset sequencer, gray coded
  typedef enum logic [1:0] {
    QDC_ST_IDLE = 2'h0,
    QDC_ST_SRST = 2'h1
  } qdc_state_t;

endpackage

// file: verilog/qdc_od_pin.sv
// one open-drain general purpose pin with synchronised read-back
`timescale 1ns/1ps
`default_nettype none
module qdc_od_pin (
  input  wire logic sys_clk_in,    // system clock
  input  wire logic resetn_in,     // async reset, active low
  input  wire logic release_in,    // 1 releases pin, 0 pulls low
  input  wire logic pin_in,        // level seen on the pin
  output var  logic pin_out,       // driven value, always low
  output var  logic pin_oe_n_out,  // low while pin is pulled low
  output var  logic level_out      // synchronised pin level
);

  logic lvl_s1_r;
  logic lvl_s2_r;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_out      <= 1'b0;
      pin_oe_n_out <= 1'b1;
      lvl_s1_r     <= 1'b1;
      lvl_s2_r     <= 1'b1;
    end else begin
      pin_out      <= 1'b0;
      pin_oe_n_out <= release_in;
      lvl_s1_r     <= pin_in;
      lvl_s2_r     <= lvl_s1_r;
    end
  end

  // read-back shows the real pin, not the written bit
  assign level_out = lvl_s2_r;

endmodule
`default_nettype wire

// file: verilog/qdc_spi_rx.sv
// serial frame receiver and read-back shifter, oversampled on the system clock
`timescale 1ns/1ps
`default_nettype none
`include "qdc_cfg.svh"
module qdc_spi_rx (
  input  wire logic        sys_clk_in,       // system clock
  input  wire logic        resetn_in,        // async reset, active low
  input  wire logic        clear_in,         // synchronous soft reset
  input  wire logic        sclk_pin_in,      // serial clock pin
  input  wire logic        cs_n_pin_in,      // frame select pin, active low
  input  wire logic        sdi_pin_in,       // serial data in pin
  input  wire logic [23:0] tx_word_in,       // word to shift out next frame
  output var  logic        frame_valid_out,  // pulse: full frame received
  output var  logic [23:0] frame_data_out,   // received frame
  output var  logic        sdo_out,          // serial data out
  output var  logic        sdo_oe_n_out      // low while frame is open
);

  logic        sclk_s1_r;
  logic        sclk_s2_r;
  logic        sclk_s3_r;
  logic        cs_s1_r;
  logic        cs_s2_r;
  logic        cs_s3_r;
  logic        sdi_s1_r;
  logic        sdi_s2_r;
  logic [23:0] shift_r;
  logic [23:0] tx_r;
  logic [4:0]  cnt_r;

  wire sclk_fall = sclk_s3_r & ~sclk_s2_r;
  wire cs_fall   = cs_s3_r & ~cs_s2_r;
  wire cs_rise   = ~cs_s3_r & cs_s2_r;
  wire in_frame  = ~cs_s2_r;
  wire cnt_full  = (cnt_r == 5'h1f);

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      cs_s1_r   <= 1'b1;
      cs_s2_r   <= 1'b1;
      cs_s3_r   <= 1'b1;
      sdi_s1_r  <= 1'b0;
      sdi_s2_r  <= 1'b0;
    end else begin
      sclk_s1_r <= sclk_pin_in;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      cs_s1_r   <= cs_n_pin_in;
      cs_s2_r   <= cs_s1_r;
      cs_s3_r   <= cs_s2_r;
      sdi_s1_r  <= sdi_pin_in;
      sdi_s2_r  <= sdi_s1_r;
    end
  end

  // data sampled and shifted on falling serial clock edges
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      shift_r         <= `QDC_FRAME_RESET;
      tx_r            <= `QDC_FRAME_RESET;
      cnt_r           <= 5'h00;
      frame_valid_out <= 1'b0;
      frame_data_out  <= `QDC_FRAME_RESET;
      sdo_oe_n_out    <= 1'b1;
    end else if (clear_in) begin
      shift_r         <= `QDC_FRAME_RESET;
      tx_r            <= `QDC_FRAME_RESET;
      cnt_r           <= 5'h00;
      frame_valid_out <= 1'b0;
      frame_data_out  <= `QDC_FRAME_RESET;
      sdo_oe_n_out    <= 1'b1;
    end else begin
      // short or long frames are dropped whole
      frame_valid_out <= cs_rise && (cnt_r == `QDC_FRAME_BITS);
      if (cs_fall) begin
        cnt_r        <= 5'h00;
        tx_r         <= tx_word_in;
        sdo_oe_n_out <= 1'b0;
      end else if (in_frame && sclk_fall) begin
        shift_r <= {shift_r[22:0], sdi_s2_r};
        tx_r    <= {tx_r[22:0], 1'b0};
        if (!cnt_full) begin
          cnt_r <= cnt_r + 5'h01;
        end
      end
      if (cs_rise) begin
        sdo_oe_n_out   <= 1'b1;
        frame_data_out <= shift_r;
      end
    end
  end

  assign sdo_out = tx_r[23];

endmodule
`default_nettype wire

// file: verilog/qdc_cmd_top.sv
// command register of a quad converter, reached over its serial port
`timescale 1ns/1ps
`default_nettype none
`include "qdc_cfg.svh"
module qdc_cmd_top #(
  parameter int CHANNELS = 4  // converter channels, fixed by the address map
) (
  input  wire logic                   sys_clk_in,               // system clock
  input  wire logic                   resetn_in,                // async reset, active low
  input  wire logic                   spi_sclk_in,              // serial clock pin
  input  wire logic                   spi_cs_n_in,              // frame select, active low
  input  wire logic                   spi_sdi_in,               // serial data in
  output var  logic                   serial_out_pin_out,       // serial data out
  output var  logic                   serial_out_pin_oe_n_out,  // low while driving
  input  wire logic                   load_latch_pin_n_in,      // latch load pin, active low
  input  wire logic [1:0]             gpio_pin_in,              // general pin levels
  output var  logic [1:0]             gpio_pin_out,             // general pin drive, low
  output var  logic [1:0]             gpio_pin_oe_n_out,        // low while pulled low
  output var  logic                   powerdown_pair_low_out,   // channels 0, 1 off
  output var  logic                   powerdown_pair_high_out,  // channels 2, 3 off
  output var  logic [16*CHANNELS-1:0] dac_latch_out             // latch words, ch0 low
);

  // ****************************************************************
  // parameter check
  // ****************************************************************
  generate
    if (CHANNELS != 4) begin : g_bad_channels
      $error("qdc_cmd_top: CHANNELS must be 4");
    end
  endgenerate

  // ****************************************************************
  // declarations
  // ****************************************************************
  qdc_pkg::qdc_state_t state_r;
  qdc_pkg::qdc_state_t state_nxt;

  logic [2:0]        srst_cnt_r;
  logic              ab_r;
  logic              sync_load_r;
  logic              pd_low_r;
  logic              pd_high_r;
  logic [1:0]        gpio_rel_r;
  logic [23:0]       rd_word_r;
  logic              ldn_s1_r;
  logic              ldn_s2_r;
  logic              ldn_s3_r;
  logic [15:0]       in_reg_r [CHANNELS];
  logic [15:0]       latch_r  [CHANNELS];
  logic [CHANNELS-1:0] dirty_r;

  logic              frame_valid;
  logic [23:0]       frame_data;
  logic [1:0]        gpio_lvl;

  // ****************************************************************
  // reset values
  // ****************************************************************
  // a macro literal cannot take a bit select, so the word is named first
  localparam logic [15:0] CMD_RST_VAL = `QDC_CMD_RESET;
  localparam logic        AB_RST      = CMD_RST_VAL[`QDC_CMD_AB];
  localparam logic        SYNC_RST    = CMD_RST_VAL[`QDC_CMD_SYNC_LOAD];
  localparam logic        PD_LOW_RST  = CMD_RST_VAL[`QDC_CMD_PD_LOW];
  localparam logic        PD_HIGH_RST = CMD_RST_VAL[`QDC_CMD_PD_HIGH];

  // ****************************************************************
  // serial port
  // ****************************************************************
  // soft clear holds the receiver too, so a half frame is lost
  wire soft_clear = (state_r == qdc_pkg::QDC_ST_SRST);

  qdc_spi_rx u_rx (
    .sys_clk_in      (sys_clk_in),
    .resetn_in       (resetn_in),
    .clear_in        (soft_clear),
    .sclk_pin_in     (spi_sclk_in),
    .cs_n_pin_in     (spi_cs_n_in),
    .sdi_pin_in      (spi_sdi_in),
    .tx_word_in      (rd_word_r),
    .frame_valid_out (frame_valid),
    .frame_data_out  (frame_data),
    .sdo_out         (serial_out_pin_out),
    .sdo_oe_n_out    (serial_out_pin_oe_n_out)
  );

  // ****************************************************************
  // frame decode
  // ****************************************************************
  wire        fr_read = frame_data[`QDC_FRAME_RW_BIT];
  wire [2:0]  fr_zero = frame_data[`QDC_FRAME_ZERO_HI:`QDC_FRAME_ZERO_LO];
  wire [3:0]  fr_addr = frame_data[`QDC_FRAME_ADDR_HI:`QDC_FRAME_ADDR_LO];
  wire [15:0] fr_data = frame_data[15:0];
  wire        fr_ok   = frame_valid && (fr_zero == 3'h0) && !soft_clear;

  wire        is_cmd  = (fr_addr == `QDC_ADDR_CMD);
  wire        is_dac  = (fr_addr[3:2] == `QDC_ADDR_DAC_BASE);
  wire [1:0]  dac_sel = fr_addr[1:0];

  wire        wr_cmd  = fr_ok && !fr_read && is_cmd;
  wire        wr_dac  = fr_ok && !fr_read && is_dac;
  wire        rd_req  = fr_ok && fr_read;

  // ****************************************************************
  // load control
  // ****************************************************************
  wire load_pin_high = ldn_s2_r;
  wire load_pin_fall = ldn_s3_r & ~ldn_s2_r;
  wire srst_start    = wr_cmd && fr_data[`QDC_CMD_RST];
  // a low load pin makes the bit a no-op
  wire sync_load_req = wr_cmd && fr_data[`QDC_CMD_SYNC_LOAD] && load_pin_high
                       && !srst_start;
  // the pin edge and the bit load the same way
  wire load_go       = load_pin_fall || sync_load_r;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ldn_s1_r <= 1'b1;
      ldn_s2_r <= 1'b1;
      ldn_s3_r <= 1'b1;
    end else begin
      ldn_s1_r <= load_latch_pin_n_in;
      ldn_s2_r <= ldn_s1_r;
      ldn_s3_r <= ldn_s2_r;
    end
  end

  // ****************************************************************
  // soft reset sequencer
  // ****************************************************************
  wire srst_last = (srst_cnt_r == (`QDC_SRST_CYCLES - 3'h1));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      qdc_pkg::QDC_ST_IDLE: begin
        if (srst_start) begin
          state_nxt = qdc_pkg::QDC_ST_SRST;
        end
      end
      qdc_pkg::QDC_ST_SRST: begin
        if (srst_last) begin
          state_nxt = qdc_pkg::QDC_ST_IDLE;
        end
      end
      default: begin
        state_nxt = qdc_pkg::QDC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r    <= qdc_pkg::QDC_ST_IDLE;
      srst_cnt_r <= 3'h0;
    end else begin
      state_r    <= state_nxt;
      srst_cnt_r <= soft_clear ? srst_cnt_r + 3'h1 : 3'h0;
    end
  end

  // ****************************************************************
  // command register
  // ****************************************************************
  // a write carrying the reset bit changes nothing else
  wire cmd_take = wr_cmd && !srst_start;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ab_r        <= AB_RST;
      sync_load_r <= SYNC_RST;
      pd_low_r    <= PD_LOW_RST;
      pd_high_r   <= PD_HIGH_RST;
      gpio_rel_r  <= `QDC_GPIO_RESET;
    end else if (soft_clear) begin
      ab_r        <= AB_RST;
      sync_load_r <= SYNC_RST;
      pd_low_r    <= PD_LOW_RST;
      pd_high_r   <= PD_HIGH_RST;
      gpio_rel_r  <= `QDC_GPIO_RESET;
    end else begin
      // the bit lives one cycle, the cycle of the update
      sync_load_r <= sync_load_req;
      if (cmd_take) begin
        ab_r          <= fr_data[`QDC_CMD_AB];
        pd_low_r      <= fr_data[`QDC_CMD_PD_LOW];
        pd_high_r     <= fr_data[`QDC_CMD_PD_HIGH];
        gpio_rel_r[1] <= fr_data[`QDC_CMD_GPIO1];
        gpio_rel_r[0] <= fr_data[`QDC_CMD_GPIO0];
      end
    end
  end

  // power-down only gates outputs, the port keeps running
  assign powerdown_pair_low_out  = pd_low_r;
  assign powerdown_pair_high_out = pd_high_r;

  // ****************************************************************
  // general purpose pins
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_gpio
      qdc_od_pin u_pin (
        .sys_clk_in   (sys_clk_in),
        .resetn_in    (resetn_in),
        .release_in   (gpio_rel_r[gi]),
        .pin_in       (gpio_pin_in[gi]),
        .pin_out      (gpio_pin_out[gi]),
        .pin_oe_n_out (gpio_pin_oe_n_out[gi]),
        .level_out    (gpio_lvl[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // channel data and latches
  // ****************************************************************
  genvar ci;
  generate
    for (ci = 0; ci < CHANNELS; ci++) begin : g_chan
      wire wr_me = wr_dac && (dac_sel == 2'(ci));

      always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          in_reg_r[ci] <= `QDC_DATA_RESET;
          latch_r[ci]  <= `QDC_DATA_RESET;
          dirty_r[ci]  <= 1'b0;
        end else if (soft_clear) begin
          in_reg_r[ci] <= `QDC_DATA_RESET;
          latch_r[ci]  <= `QDC_DATA_RESET;
          dirty_r[ci]  <= 1'b0;
        end else begin
          if (wr_me) begin
            in_reg_r[ci] <= fr_data;
          end
          if (load_go && dirty_r[ci]) begin
            latch_r[ci] <= in_reg_r[ci];
          end
          // a write in the load cycle stays pending
          if (wr_me) begin
            dirty_r[ci] <= 1'b1;
          end else if (load_go) begin
            dirty_r[ci] <= 1'b0;
          end
        end
      end

      assign dac_latch_out[16*ci +: 16] = latch_r[ci];
    end
  endgenerate

  // ****************************************************************
  // read-back
  // ****************************************************************
  wire [15:0] cmd_view = {ab_r,
                          sync_load_r,
                          soft_clear,
                          pd_low_r,
                          pd_high_r,
                          1'b0,
                          gpio_lvl[1],
                          gpio_lvl[0],
                          `QDC_CMD_LOW_FIXED};
  wire [15:0] dac_view = ab_r ? latch_r[dac_sel] : in_reg_r[dac_sel];
  wire [15:0] rd_val   = is_cmd ? cmd_view :
                         is_dac ? dac_view : 16'h0000;
  wire [23:0] rd_frame = {1'b1, 3'h0, fr_addr, rd_val};

  // the word is held until the next full 24-bit frame ends
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_word_r <= `QDC_FRAME_RESET;
    end else if (soft_clear) begin
      rd_word_r <= `QDC_FRAME_RESET;
    end else if (frame_valid) begin
      rd_word_r <= rd_req ? rd_frame : `QDC_FRAME_RESET;
    end
  end

endmodule
`default_nettype wire

// file: tb/qdc_cmd_checker.sv
// concurrent port checks for the quad converter command register block
`timescale 1ns/1ps
`default_nettype none
module qdc_cmd_checker #(
  parameter int CHANNELS = 4  // converter channels
) (
  input wire logic                   sys_clk_in,               // system clock
  input wire logic                   resetn_in,                // async reset, active low
  input wire logic                   spi_cs_n_in,              // frame select
  input wire logic                   load_latch_pin_n_in,      // latch load pin
  input wire logic                   serial_out_pin_oe_n_out,  // serial out enable
  input wire logic [1:0]             gpio_pin_out,             // general pin drive
  input wire logic [1:0]             gpio_pin_oe_n_out,        // general pin enable
  input wire logic                   powerdown_pair_low_out,   // channels 0, 1 off
  input wire logic                   powerdown_pair_high_out,  // channels 2, 3 off
  input wire logic [16*CHANNELS-1:0] dac_latch_out             // latch words
);
  // ****************************************************************
  // cycles since the last frame end and since the load pin was low
  // ****************************************************************
  logic [3:0] cs_age_r;
  logic [3:0] cs_age_nxt;
  logic [3:0] pin_age_r;
  logic [3:0] pin_age_nxt;
  // both age from the end of the low level; saturating, so a quiet spell never wraps
  assign cs_age_nxt  = !spi_cs_n_in ? 4'h0 : (cs_age_r == 4'hf) ? cs_age_r : cs_age_r + 4'h1;
  assign pin_age_nxt = !load_latch_pin_n_in ? 4'h0 :
                       (pin_age_r == 4'hf) ? pin_age_r : pin_age_r + 4'h1;
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cs_age_r  <= 4'hf;
      pin_age_r <= 4'hf;
    end else begin
      cs_age_r  <= cs_age_nxt;
      pin_age_r <= pin_age_nxt;
    end
  end

  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_cs_idle; spi_cs_n_in [*8]; endsequence
  sequence s_cs_open; !spi_cs_n_in [*8]; endsequence
  sequence s_pin_held; !load_latch_pin_n_in [*8]; endsequence

  property p_sdo_idle; s_cs_idle |-> serial_out_pin_oe_n_out; endproperty
  a_sdo_idle: assert property (p_sdo_idle)
    else $error("serial out driven outside a frame");
  property p_sdo_open; s_cs_open |-> !serial_out_pin_oe_n_out; endproperty
  a_sdo_open: assert property (p_sdo_open)
    else $error("serial out not driven inside a frame");
  property p_gpio_low; gpio_pin_out == 2'h0; endproperty
  a_gpio_low: assert property (p_gpio_low)
    else $error("general pin driven high");
  property p_gpio_oe; $changed(gpio_pin_oe_n_out) |-> cs_age_r < 4'ha; endproperty
  a_gpio_oe: assert property (p_gpio_oe)
    else $error("general pin enable moved without a frame");
  property p_pd_low; $changed(powerdown_pair_low_out) |-> cs_age_r < 4'ha; endproperty
  a_pd_low: assert property (p_pd_low)
    else $error("low pair power-down moved without a frame");
  property p_pd_high; $changed(powerdown_pair_high_out) |-> cs_age_r < 4'ha; endproperty
  a_pd_high: assert property (p_pd_high)
    else $error("high pair power-down moved without a frame");
  property p_latch_cause;
    $changed(dac_latch_out) |-> (cs_age_r < 4'ha) || (pin_age_r < 4'ha);
  endproperty
  a_latch_cause: assert property (p_latch_cause)
    else $error("latch changed without a load");
  property p_pin_held; s_pin_held |-> $stable(dac_latch_out) || dac_latch_out == '0; endproperty
  a_pin_held: assert property (p_pin_held)
    else $error("latch reloaded while load pin held low");
  property p_rst_vals;
    $rose(resetn_in) |-> gpio_pin_oe_n_out == 2'h3 && !powerdown_pair_low_out
      && !powerdown_pair_high_out && dac_latch_out == '0;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("outputs not at reset values");
endmodule

bind qdc_cmd_top qdc_cmd_checker #(.CHANNELS(CHANNELS)) u_chk (
  .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .spi_cs_n_in(spi_cs_n_in),
  .load_latch_pin_n_in(load_latch_pin_n_in), .serial_out_pin_oe_n_out(serial_out_pin_oe_n_out),
  .gpio_pin_out(gpio_pin_out), .gpio_pin_oe_n_out(gpio_pin_oe_n_out),
  .powerdown_pair_low_out(powerdown_pair_low_out),
  .powerdown_pair_high_out(powerdown_pair_high_out), .dac_latch_out(dac_latch_out)
);
`default_nettype wire

// file: tb/qdc_host_model.sv
// host serial controller model: frames of 24 bits, clock idle low
`timescale 1ns/1ps
`default_nettype none
module qdc_host_model (
  input  wire logic sys_clk_in,  // system clock
  input  wire logic sdo_in,      // serial out wire level
  output var  logic sclk_out,    // serial clock, still between frames
  output var  logic cs_n_out,    // frame select, active low
  output var  logic sdi_out      // serial data in
);
  int half = 5;  // sys clocks per clock phase; raised for a slow host
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out  = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  // data changes on the rising side so it is settled at the falling sample
  task automatic xfer(input logic [23:0] w, output logic [23:0] r);
    wt(1);
    cs_n_out = 1'b0;
    wt(half);
    for (int i = 23; i >= 0; i--) begin
      sclk_out = 1'b1;
      sdi_out  = w[i];
      wt(half);
      r[i]     = sdo_in;
      sclk_out = 1'b0;
      wt(half);
    end
    cs_n_out = 1'b1;
    sdi_out  = ~sdi_out;  // released line must not keep the last bit
    wt(8);
  endtask
endmodule
`default_nettype wire

// file: tb/tb_qdc_cmd_top.sv
// self-checking bench for the quad converter command register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_qdc_cmd_top;
  logic        sys_clk_in;
  logic        resetn_in;
  logic        load_n;
  logic [1:0]  ext_low;  // outside party pulling a general pin low
  wire         sclk, cs_n, sdi, sdo_w;
  logic        serial_out_pin, sdo_oe_n, pd_lo, pd_hi;
  logic [1:0]  gp_out, gp_oe_n;
  wire  [1:0]  gp_w;
  logic [63:0] latch;
  logic [15:0] din [4];
  logic [15:0] lat [4];
  logic [15:0] w;
  logic [23:0] r;
  int          fail_count, n_tests, seed;

  // pins pulled up; released serial out shows the inverse, not a held value
  assign gp_w  = (gp_oe_n | gp_out) & ~ext_low;
  assign sdo_w = sdo_oe_n ? ~serial_out_pin : serial_out_pin;

  qdc_cmd_top #(.CHANNELS(4)) dut (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .spi_sclk_in(sclk),
    .spi_cs_n_in(cs_n), .spi_sdi_in(sdi), .serial_out_pin_out(serial_out_pin),
    .serial_out_pin_oe_n_out(sdo_oe_n), .load_latch_pin_n_in(load_n),
    .gpio_pin_in(gp_w), .gpio_pin_out(gp_out), .gpio_pin_oe_n_out(gp_oe_n),
    .powerdown_pair_low_out(pd_lo), .powerdown_pair_high_out(pd_hi), .dac_latch_out(latch)
  );
  qdc_host_model u_host (
    .sys_clk_in(sys_clk_in), .sdo_in(sdo_w), .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  function automatic logic [15:0] cmd_exp(input logic [15:0] v, input logic [1:0] ext);
    return {v[15], 2'b00, v[12:11], 1'b0, v[9:8] & ~ext, 8'h3c};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    u_host.xfer({4'h0, a, d}, r);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e, input string nm);
    u_host.xfer({4'h8, a, 16'h0000}, r);
    u_host.xfer(24'h80_0000, r);
    `CHK(nm, {4'h8, a, e}, r)
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    tick(60000);
    fail_count++;
    tally_and_finish();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    seed       = 98929;
    resetn_in  = 1'b0;
    load_n     = 1'b1;
    ext_low    = 2'b00;
    fail_count = 0;
    n_tests    = 0;
    for (int c = 0; c < 4; c++) lat[c] = 16'h0000;
    tick(6);
    resetn_in = 1'b1;
    tick(4);
    `CHK("power-down", 2'b00, {pd_lo, pd_hi})
    `CHK("gpio enable", 2'b11, gp_oe_n)
    rd_chk(4'h0, 16'h033c, "cmd reset");
    // random command writes, reserved bit always written 1, pins pulled at random
    for (int n = 0; n < 12; n++) begin
      w       = $random(seed);
      w[14:13] = 2'b00;
      w[10]   = 1'b1;
      ext_low = $random(seed);
      u_host.half = 5 + n % 4;
      wr(4'h0, w);
      `CHK("pd low", w[12], pd_lo)
      `CHK("pd high", w[11], pd_hi)
      `CHK("gpio enable", w[9:8], gp_oe_n)
      rd_chk(4'h0, cmd_exp(w, ext_low), "cmd");
    end
    u_host.xfer(24'h10_1800, r);  // stray bit in the zero field
    `CHK("ignored frame", {w[12], w[11]}, {pd_lo, pd_hi})
    u_host.half = 5;
    ext_low = 2'b00;
    wr(4'h0, 16'h0300);
    for (int c = 0; c < 4; c++) begin
      din[c] = $random(seed);
      wr(4'h4 + 4'(c), din[c]);
      rd_chk(4'h4 + 4'(c), din[c], "input reg");
    end
    wr(4'h0, 16'h8300);
    rd_chk(4'h5, 16'h0000, "latch before load");
    wr(4'h0, 16'hc300);
    for (int c = 0; c < 4; c++) lat[c] = din[c];
    `CHK("latch bit load", {lat[3], lat[2], lat[1], lat[0]}, latch)
    rd_chk(4'h0, 16'h833c, "load bit cleared");
    din[2] = $random(seed);
    wr(4'h6, din[2]);
    load_n = 1'b0;
    tick(8);
    load_n = 1'b1;
    lat[2] = din[2];
    tick(4);
    `CHK("latch pin load", {lat[3], lat[2], lat[1], lat[0]}, latch)
    rd_chk(4'h6, din[2], "latch read");
    load_n = 1'b0;
    din[1] = $random(seed);
    wr(4'h5, din[1]);
    wr(4'h0, 16'hc300);
    `CHK("load bit ignored", {lat[3], lat[2], lat[1], lat[0]}, latch)
    load_n = 1'b1;
    tick(4);
    wr(4'h0, 16'hc300);
    lat[1] = din[1];
    `CHK("latch dirty only", {lat[3], lat[2], lat[1], lat[0]}, latch)
    wr(4'h0, 16'h1a00);
    wr(4'h0, 16'h3c00);  // soft reset, other bits of the write dropped
    tick(12);
    `CHK("soft reset pd", 2'b00, {pd_lo, pd_hi})
    `CHK("soft reset gpio", 2'b11, gp_oe_n)
    `CHK("soft reset latch", 64'h0000_0000_0000_0000, latch)
    rd_chk(4'h0, 16'h033c, "cmd after soft reset");
    rd_chk(4'h7, 16'h0000, "input reg after soft reset");
    tally_and_finish();
  end
endmodule
`default_nettype wire
